/* File: flash_prot_defines.vh */
`ifndef FLASH_PROT_DEFINES_VH
`define FLASH_PROT_DEFINES_VH
// Register byte offsets
`define REG_FADDR      8'h00
`define REG_FDATA      8'h04
`define REG_CTRL       8'h08
`define REG_RIS        8'h0c
`define REG_IMR        8'h10
`define REG_MIS        8'h14
`define REG_PROT_SEL   8'h18
`define REG_PROT_VAL   8'h1c
`define REG_USER0      8'h20
`define REG_USER1      8'h24
`define REG_STAT       8'h28
// Control register bits
`define CTRL_PROG      0
`define CTRL_ERASE     1
`define CTRL_SAVE_PROT 2
`define CTRL_SAVE_USER 3
// Interrupt status bits
`define INT_PROGRAM    0
`define INT_ACCESS     1
`define INT_W          2
// Protection codes, ordered by stringency
`define PROT_READ_WRITE 2'h0
`define PROT_READ_ONLY  2'h1
`define PROT_EXEC_ONLY  2'h2
// Far-side operation codes
`define OP_PROG        2'h0
`define OP_ERASE       2'h1
`define OP_SAVE_PROT   2'h2
`define OP_SAVE_USER   2'h3
// Region and erase block sizes as address bit positions
`define REGION_SHIFT   11
`define BLOCK_SHIFT    10
`endif

/* File: flash_protection_controller.v */
// Overview of operation
// [RL1] Interrupt status readable raw and masked by the enable register.
// [RL2] Status has a program/erase done flag and an access violation flag.
// [RL3] Requester programs whole words; address and count multiples of four.
// [RL4] Requester writes each word once between erases of its page.
// [RL5] One protection state per 2 kB region: read/write, read-only, exec-only.
// [RL6] Read-only allows read and fetch; exec-only allows only fetch.
// [RL7] Protection changes only toward stricter; loosening blocked in hardware.
// [RL8] Exec-only regions ignore any further protection change.
// [RL9] Uncommitted changes act at once but last only until reset.
// [RL10] Commit makes protection permanent and signals completion.
// [RL11] Two user registers, 0 and 1, readable and writable.
// [RL12] Separate commit makes user registers permanent.
// [RL13] Access flag on program/erase of protected or data read of exec-only.
// [RL14] Erase sets a whole block to ones; program only clears bits.
// [RL15] Only enabled interrupt sources drive the interrupt output.
// [RL16] Writing one clears a raw status flag; zero leaves it.
// [RL17] Error status on failed, protected or invalid program/erase/commit.
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_defines.vh"

module flash_protection_controller #(
  parameter ADDR_W  = 17,
  parameter REGIONS = 64
) (
  input  wire                 CLK,
  input  wire                 SYS_RST,
  input  wire [7:0]           REG_ADDR,
  input  wire [31:0]          REG_WDATA,
  input  wire                 REG_WR,
  input  wire                 REG_RD,
  output reg  [31:0]          REG_RDATA,
  input  wire                 ACC_VALID,
  input  wire                 ACC_FETCH,
  input  wire [ADDR_W-1:0]    ACC_ADDR,
  output wire                 ACC_GRANT,
  output reg                  FL_START,
  output reg  [1:0]           FL_OP,
  output reg  [ADDR_W-1:0]    FL_ADDR,
  output reg  [31:0]          FL_WDATA,
  input  wire                 FL_DONE,
  input  wire                 FL_FAIL,
  output reg  [2*REGIONS-1:0] PROT_STATE,
  output reg  [31:0]          USER0,
  output reg  [31:0]          USER1,
  input  wire [2*REGIONS-1:0] NV_PROT,
  input  wire [31:0]          NV_USER0,
  input  wire [31:0]          NV_USER1,
  output wire                 IRQ
);

  // Sequencer states: one far-side operation runs at a time
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // Software-visible state and per-cycle decode results
  reg               state;
  reg               load_pend;
  reg [ADDR_W-1:0]  faddr;
  reg [31:0]        fdata;
  reg [`INT_W-1:0]  ris;
  reg [`INT_W-1:0]  imr;
  reg [5:0]         prot_sel;
  reg               err;
  reg               next_err;
  reg               start_op;
  reg [1:0]         start_code;
  reg               op_viol;
  reg               prot_viol;
  reg               prot_bad;
  reg [`INT_W-1:0]  set_ris;
  reg [31:0]        rd_val;

  // Region index of a flash byte address
  // Six index bits cover the 64 regions of a full-size array
  function [5:0] region_of;
    input [ADDR_W-1:0] a;
    begin
      region_of = a[`REGION_SHIFT+5:`REGION_SHIFT];
    end
  endfunction

  // Protection code held for one region
  // Two bits per region: region i sits at bits 2i+1 and 2i
  function [1:0] prot_at;
    input [2*REGIONS-1:0] p;
    input [5:0]           idx;
    begin
      prot_at = p[idx*2 +: 2];
    end
  endfunction

  // Codes seen by the access port, the pending operation and the window
  wire [1:0] acc_prot = prot_at(PROT_STATE, region_of(ACC_ADDR));
  wire [1:0] op_prot  = prot_at(PROT_STATE, region_of(faddr));
  wire [1:0] sel_prot = prot_at(PROT_STATE, prot_sel);
  wire [1:0] new_prot = REG_WDATA[1:0];
  wire       wr_ctrl  = REG_WR && (REG_ADDR == `REG_CTRL);
  wire       wr_prot  = REG_WR && (REG_ADDR == `REG_PROT_VAL);
  wire       data_rd  = ACC_VALID && !ACC_FETCH;

  // One decode per software register; the strobe lasts a single cycle,
  // so each decode is high at exactly one edge per write.
  wire       wr_faddr = REG_WR && (REG_ADDR == `REG_FADDR);
  wire       wr_fdata = REG_WR && (REG_ADDR == `REG_FDATA);
  wire       wr_ris   = REG_WR && (REG_ADDR == `REG_RIS);
  wire       wr_imr   = REG_WR && (REG_ADDR == `REG_IMR);
  wire       wr_sel   = REG_WR && (REG_ADDR == `REG_PROT_SEL);
  wire       wr_user0 = REG_WR && (REG_ADDR == `REG_USER0);
  wire       wr_user1 = REG_WR && (REG_ADDR == `REG_USER1);

  // Completion counts only while an operation runs; a stray done pulse
  // from the array while idle is ignored rather than reported.
  wire       op_done  = (state == ST_BUSY) && FL_DONE;

  // A refused protection write: loosening, an unknown code, a region
  // beyond the array or a region already frozen in exec-only.
  wire       prot_nak = wr_prot && (prot_bad || prot_viol); // [RL7] [RL8]

  // Fetch is always allowed; data reads are refused only in exec-only
  // regions. Debugger reads arrive on the same port as data reads.
  // Combinational, so a fetch never loses a cycle to the check.
  assign ACC_GRANT = ACC_VALID &&
                     (ACC_FETCH || acc_prot != `PROT_EXEC_ONLY); // [RL6]

  // Interrupt output follows only the enabled raw flags
  // Level output: it drops as soon as the flag is cleared or masked
  assign IRQ = |(ris & imr); // [RL15]

  // Classify a control write: which operation and whether it is refused.
  // A control write while busy is dropped without touching the error bit,
  // so software must poll busy before starting the next operation.
  // Priority follows bit order: program, erase, then the two commits.
  always @* begin
    start_op   = 1'b0;
    start_code = `OP_PROG;
    op_viol    = 1'b0;
    next_err   = err;
    if (wr_ctrl && state == ST_IDLE) begin
      if (REG_WDATA[`CTRL_PROG]) begin
        start_code = `OP_PROG;
        start_op   = 1'b1;
      end else if (REG_WDATA[`CTRL_ERASE]) begin
        start_code = `OP_ERASE;
        start_op   = 1'b1;
      end else if (REG_WDATA[`CTRL_SAVE_PROT]) begin
        start_code = `OP_SAVE_PROT;
        start_op   = 1'b1;
      end else if (REG_WDATA[`CTRL_SAVE_USER]) begin
        start_code = `OP_SAVE_USER;
        start_op   = 1'b1;
      end
      // Program and erase may not touch read-only or exec-only regions
      if (start_op && (start_code == `OP_PROG ||
                       start_code == `OP_ERASE) &&
          op_prot != `PROT_READ_WRITE) begin
        op_viol  = 1'b1; // [RL6] [RL13]
      end
      if (start_op) begin
        // Misaligned word or region beyond the array is an error too
        next_err = op_viol ||
                   (start_code == `OP_PROG && faddr[1:0] != 2'h0) ||
                   region_of(faddr) >= REGIONS; // [RL3] [RL17]
      end
    end
    // The error bit reports the last event that could fail: an
    // operation start, its completion, or a protection write.
    if (op_done) begin
      next_err = FL_FAIL; // [RL17]
    end
    if (wr_prot) begin
      next_err = prot_nak; // [RL7] [RL17]
    end
    // Completion and a protection write in one edge: a failure from
    // either one must stay visible, so neither may hide the other.
    if (op_done && wr_prot) begin
      next_err = FL_FAIL || prot_nak; // [RL17]
    end
  end

  // A protection write is refused when it loosens, names a code that does
  // not exist, or targets an exec-only region.
  // Equal codes pass, so rewriting a read/write or read-only code is quiet.
  always @* begin
    prot_bad  = (new_prot > `PROT_EXEC_ONLY) || (prot_sel >= REGIONS);
    prot_viol = (new_prot < sel_prot) ||
                (sel_prot == `PROT_EXEC_ONLY); // [RL7] [RL8]
  end

  // Events for the raw status register
  // Refused operations never reach the array, so they never set done
  always @* begin
    set_ris = {`INT_W{1'b0}};
    set_ris[`INT_PROGRAM] = op_done; // [RL2] [RL10]
    set_ris[`INT_ACCESS]  = op_viol ||
                            (data_rd && !ACC_GRANT); // [RL2] [RL13]
  end

  // Operation sequencer towards the flash array
  // FL_OP, FL_ADDR and FL_WDATA hold until the next start, so the array
  // may sample them at any point while the operation runs.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state    <= ST_IDLE;
      FL_START <= 1'b0;
      FL_OP    <= `OP_PROG;
      FL_ADDR  <= {ADDR_W{1'b0}};
      FL_WDATA <= 32'h0;
    end else begin
      FL_START <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Refused requests stay idle; the error bit tells why
          if (start_op && !next_err) begin
            FL_START <= 1'b1;
            FL_OP    <= start_code;
            FL_WDATA <= fdata;
            state    <= ST_BUSY;
            if (start_code == `OP_ERASE) begin
              // Erase covers the whole block, which the array sets to ones
              FL_ADDR <= {faddr[ADDR_W-1:`BLOCK_SHIFT],
                          {`BLOCK_SHIFT{1'b0}}}; // [RL14]
            end else begin
              FL_ADDR <= faddr;
            end
          end
        end
        ST_BUSY: begin
          // Completion is signalled by the array for all four operations
          // Its fail line is only trusted beside the done pulse
          if (FL_DONE) begin
            state <= ST_IDLE; // [RL10] [RL12]
          end
        end
        default: begin
          // Unused code: fall back to idle
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Programming presents a word whose zero bits are the bits to clear;
  // the array never turns a zero back into a one without an erase.
  // Re-programming a word before its page is erased is the caller's
  // responsibility and is not checked here. [RL4] [RL14]

  // Protection state: reset clears it, then the committed copy is loaded
  // in the first cycle after release. Writes act at once. [RL5] [RL9]
  // A user or protection write in that load cycle is lost under the
  // committed copy, so software waits one cycle after reset. Commit
  // sends nothing back: the array keeps its own copy until next reset.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PROT_STATE <= {2*REGIONS{1'b0}};
      USER0      <= 32'h0;
      USER1      <= 32'h0;
      load_pend  <= 1'b1;
    end else if (load_pend) begin
      PROT_STATE <= NV_PROT; // [RL9] [RL10]
      USER0      <= NV_USER0; // [RL12]
      USER1      <= NV_USER1;
      load_pend  <= 1'b0;
    end else begin
      if (wr_prot && !prot_bad && !prot_viol) begin
        PROT_STATE[prot_sel*2 +: 2] <= new_prot; // [RL7] [RL9]
      end
      if (wr_user0) begin
        USER0 <= REG_WDATA; // [RL11]
      end
      if (wr_user1) begin
        USER1 <= REG_WDATA; // [RL11]
      end
    end
  end

  // Software registers; a set in the clear cycle wins over the clear
  // Mask and select are plain storage; only the raw flags have side
  // effects, and the set term is ORed in after the clear.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      faddr    <= {ADDR_W{1'b0}};
      fdata    <= 32'h0;
      ris      <= {`INT_W{1'b0}};
      imr      <= {`INT_W{1'b0}};
      prot_sel <= 6'h0;
      err      <= 1'b0;
    end else begin
      err <= next_err;
      if (wr_faddr) begin
        faddr <= REG_WDATA[ADDR_W-1:0];
      end
      if (wr_fdata) begin
        fdata <= REG_WDATA;
      end
      if (wr_imr) begin
        imr <= REG_WDATA[`INT_W-1:0];
      end
      if (wr_sel) begin
        prot_sel <= REG_WDATA[5:0];
      end
      if (wr_ris) begin
        ris <= (ris & ~REG_WDATA[`INT_W-1:0]) | set_ris; // [RL16]
      end else begin
        ris <= ris | set_ris; // [RL2]
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  // Busy is the only readable control bit; start bits do not stay set
  always @* begin
    rd_val = 32'h0;
    case (REG_ADDR)
      `REG_FADDR:    rd_val[ADDR_W-1:0] = faddr;
      `REG_FDATA:    rd_val = fdata;
      `REG_CTRL:     rd_val[0] = state;
      `REG_RIS:      rd_val[`INT_W-1:0] = ris; // [RL1]
      `REG_IMR:      rd_val[`INT_W-1:0] = imr;
      `REG_MIS:      rd_val[`INT_W-1:0] = ris & imr; // [RL1]
      `REG_PROT_SEL: rd_val[5:0] = prot_sel;
      `REG_PROT_VAL: rd_val[1:0] = sel_prot; // [RL5]
      `REG_USER0:    rd_val = USER0; // [RL11]
      `REG_USER1:    rd_val = USER1;
      `REG_STAT:     rd_val[0] = err; // [RL17]
      default:       rd_val = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle keeps stale data off a shared return path
  always @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      REG_RDATA <= rd_val;
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

endmodule // flash_protection_controller
`default_nettype wire

/* File: prot_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_defines.vh"
module prot_sva #(
  parameter ADDR_W  = 17,
  parameter REGIONS = 64
) (
  input wire logic                 CLK,
  input wire logic                 SYS_RST,
  input wire logic [7:0]           REG_ADDR,
  input wire logic                 REG_WR,
  input wire logic                 ACC_VALID,
  input wire logic                 ACC_FETCH,
  input wire logic [ADDR_W-1:0]    ACC_ADDR,
  input wire logic                 ACC_GRANT,
  input wire logic                 FL_START,
  input wire logic [1:0]           FL_OP,
  input wire logic [ADDR_W-1:0]    FL_ADDR,
  input wire logic [2*REGIONS-1:0] PROT_STATE,
  input wire logic [2*REGIONS-1:0] NV_PROT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Code of the region holding an address
  function automatic [1:0] code(input [2*REGIONS-1:0] p,
                                input [ADDR_W-1:0] a);
    code = p[2*(a>>`REGION_SHIFT) +: 2];
  endfunction
  // Any region loosened, or (xo) an exec-only region touched
  function automatic bit bad(input [2*REGIONS-1:0] o, n, input bit xo);
    bad = 0;
    for (int i = 0; i < REGIONS; i++)
      if (xo ? (o[2*i+:2] == `PROT_EXEC_ONLY && n[2*i+:2] != o[2*i+:2])
             : (n[2*i+:2] < o[2*i+:2])) bad = 1;
  endfunction
  AST_XO_NO_DATA: assert property (
    ACC_VALID && !ACC_FETCH && code(PROT_STATE, ACC_ADDR) ==
    `PROT_EXEC_ONLY |-> !ACC_GRANT) else $error("exec-only data read");
  AST_GRANT_OK: assert property (
    ACC_VALID && (ACC_FETCH || code(PROT_STATE, ACC_ADDR) !=
    `PROT_EXEC_ONLY) |-> ACC_GRANT) else $error("legal access refused");
  // Skip the load edges, where committed values may replace anything
  AST_NO_LOOSEN: assert property (
    !$past(SYS_RST) && !$past(SYS_RST, 2) |->
    !bad($past(PROT_STATE), PROT_STATE, 1'b0)) else $error("loosened");
  AST_XO_FROZEN: assert property (
    !$past(SYS_RST) && !$past(SYS_RST, 2) |->
    !bad($past(PROT_STATE), PROT_STATE, 1'b1)) else $error("xo changed");
  AST_NV_LOAD: assert property (
    $fell(SYS_RST) |=> PROT_STATE == $past(NV_PROT))
    else $error("committed protection not loaded");
  AST_START_CAUSE: assert property (
    FL_START |-> $past(REG_WR && REG_ADDR == `REG_CTRL))
    else $error("op started without control write");
  AST_ERASE_ALIGN: assert property (
    FL_START && FL_OP == `OP_ERASE |-> FL_ADDR[`BLOCK_SHIFT-1:0] == 0)
    else $error("erase not block aligned");
  AST_PROG_RW: assert property (
    FL_START && FL_OP <= `OP_ERASE |->
    code(PROT_STATE, FL_ADDR) == `PROT_READ_WRITE)
    else $error("write op in protected region");
  AST_PROG_ALIGN: assert property (
    FL_START && FL_OP == `OP_PROG |-> FL_ADDR[1:0] == 2'h0)
    else $error("unaligned program started");
  cover property (FL_START && FL_OP == `OP_SAVE_PROT);
  cover property (ACC_VALID && !ACC_GRANT);
  cover property ($fell(SYS_RST));
endmodule // prot_sva
bind flash_protection_controller prot_sva #(
  .ADDR_W(ADDR_W), .REGIONS(REGIONS)) chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .ACC_VALID(ACC_VALID), .ACC_FETCH(ACC_FETCH), .ACC_ADDR(ACC_ADDR),
  .ACC_GRANT(ACC_GRANT), .FL_START(FL_START), .FL_OP(FL_OP),
  .FL_ADDR(FL_ADDR), .PROT_STATE(PROT_STATE), .NV_PROT(NV_PROT));
`default_nettype wire

/* File: flash_array_model.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic FL_START,
  input  wire logic FAIL_REQ,
  output var  logic FL_DONE,
  output var  logic FL_FAIL
);
  logic [2:0] cnt;
  // Random latency; fail toggles outside done, where it is never trusted
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cnt <= 3'h0;
      FL_DONE <= 1'b0;
      FL_FAIL <= 1'b0;
    end else begin
      FL_DONE <= (cnt == 3'h1);
      FL_FAIL <= (cnt == 3'h1) ? FAIL_REQ : ~FL_FAIL;
      if (FL_START) cnt <= 3'(1 + $urandom_range(5));
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
  end
endmodule // flash_array_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_defines.vh"
module testbench;
  logic         CLK, SYS_RST, REG_WR, REG_RD, ACC_VALID, ACC_FETCH;
  logic         ACC_GRANT, FL_START, FL_DONE, FL_FAIL, IRQ, fail_req;
  logic         rd_q = 1'b0;
  logic [7:0]   REG_ADDR;
  logic [31:0]  REG_WDATA, REG_RDATA, FL_WDATA, USER0, USER1, u0, u1, v;
  logic [16:0]  ACC_ADDR, FL_ADDR;
  logic [127:0] PROT_STATE, NV_PROT;
  logic [1:0]   FL_OP;
  logic [15:0]  tab[5] = '{16'h3110, 16'h3011, 16'h3220, 16'h1121, 16'h4301};
  int           n_fail = 0, num_checks = 0, cyc = 0, i;
  logic [31:0]  expq[$];
  string        nameq[$];
  flash_protection_controller dut (.CLK(CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC_VALID(ACC_VALID),
    .ACC_FETCH(ACC_FETCH), .ACC_ADDR(ACC_ADDR), .ACC_GRANT(ACC_GRANT),
    .FL_START(FL_START), .FL_OP(FL_OP), .FL_ADDR(FL_ADDR),
    .FL_WDATA(FL_WDATA), .FL_DONE(FL_DONE), .FL_FAIL(FL_FAIL),
    .PROT_STATE(PROT_STATE), .USER0(USER0), .USER1(USER1),
    .NV_PROT(NV_PROT), .NV_USER0(u0), .NV_USER1(u1), .IRQ(IRQ));
  flash_array_model far (.CLK(CLK), .SYS_RST(SYS_RST), .FL_START(FL_START),
    .FAIL_REQ(fail_req), .FL_DONE(FL_DONE), .FL_FAIL(FL_FAIL));
  initial begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  task chk(input string n, input logic [127:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge CLK) begin
    if (rd_q) chk(nameq.pop_front(), REG_RDATA, expq.pop_front());
    rd_q <= REG_RD;
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_fail++;
      finish_test;
    end
  end
  // One-cycle strobe; a gap edge keeps strobes from being set twice
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge CLK);
    REG_WR <= w; REG_RD <= !w; REG_ADDR <= a; REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 0; REG_RD <= 0;
  endtask
  task rd(input string n, input [7:0] a, input [31:0] e);
    nameq.push_back(n); expq.push_back(e); bus(0, a, 32'h0);
  endtask
  task acc(input [5:0] r, input f, input g);
    @(posedge CLK);
    ACC_VALID <= 1; ACC_FETCH <= f; ACC_ADDR <= {r, 11'($urandom)};
    #1 chk("grant", ACC_GRANT, g);
    @(posedge CLK);
    ACC_VALID <= 0;
  endtask
  // Start an op and wait, bounded, for the array to finish it
  task go(input [3:0] c, input [1:0] op);
    bus(1, `REG_CTRL, c);
    #1 i = 0;
    while (FL_START !== 1'b1 && i < 9) begin @(posedge CLK); #1 i++; end
    chk("op", FL_OP, op);
    while (FL_DONE !== 1'b1 && i < 20) begin @(posedge CLK); #1 i++; end
    @(posedge CLK);
  endtask
  task rst;
    SYS_RST <= 1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 0;
    repeat (2) @(posedge CLK);
  endtask
  initial begin
    void'($urandom(32'hf7423ead));
    {SYS_RST, REG_WR, REG_RD, ACC_VALID, ACC_FETCH, fail_req} = 6'h20;
    REG_ADDR = 0; REG_WDATA = 0; ACC_ADDR = 0;
    u0 = $urandom; u1 = $urandom; v = $urandom;
    NV_PROT = 128'h18; // Region 1 exec-only, region 2 read-only
    rst;
    rd("user0", `REG_USER0, u0);
    chk("user0 pin", USER0, u0);
    bus(1, `REG_USER1, v);
    rd("user1", `REG_USER1, v);
    chk("user1 pin", USER1, v);
    $display("test 1 done");
    foreach (tab[k]) begin
      bus(1, `REG_PROT_SEL, tab[k][15:12]);
      bus(1, `REG_PROT_VAL, tab[k][11:8]);
      rd("prot", `REG_PROT_VAL, tab[k][7:4]);
      rd("err", `REG_STAT, tab[k][3:0]);
    end
    chk("prot map", PROT_STATE, 128'h98);
    $display("test 2 done");
    acc(1, 0, 0);
    acc(1, 1, 1);
    acc(2, 0, 1);
    rd("ris", `REG_RIS, 2);
    bus(1, `REG_RIS, 2);
    rd("ris", `REG_RIS, 0);
    $display("test 3 done");
    bus(1, `REG_IMR, 1);
    bus(1, `REG_FADDR, 32'h104);
    bus(1, `REG_FDATA, v);
    go(4'h1, `OP_PROG);
    #1 chk("wdata", FL_WDATA, v);
    chk("irq", IRQ, 1);
    rd("mis", `REG_MIS, 1);
    bus(1, `REG_IMR, 2);
    #1 chk("irq", IRQ, 0);
    bus(1, `REG_RIS, 0);
    rd("ris", `REG_RIS, 1);
    bus(1, `REG_RIS, 1);
    rd("ris", `REG_RIS, 0);
    $display("test 4 done");
    fail_req <= 1;
    bus(1, `REG_FADDR, 32'h7fc);
    go(4'h2, `OP_ERASE);
    chk("eaddr", FL_ADDR, 17'h400);
    rd("err", `REG_STAT, 1);
    fail_req <= 0;
    bus(1, `REG_FADDR, 32'h1000);
    bus(1, `REG_CTRL, 2);
    rd("err", `REG_STAT, 1);
    rd("ris", `REG_RIS, 3);
    $display("test 5 done");
    go(4'h4, `OP_SAVE_PROT);
    rd("busy", `REG_CTRL, 0);
    go(4'h8, `OP_SAVE_USER);
    bus(1, `REG_FADDR, 32'h106);
    bus(1, `REG_CTRL, 1);
    #1 chk("start", FL_START, 0);
    rd("err", `REG_STAT, 1);
    rst;
    bus(1, `REG_PROT_SEL, 3);
    rd("prot", `REG_PROT_VAL, 0);
    rd("user1", `REG_USER1, u1);
    $display("test 6 done");
    repeat (3) @(posedge CLK);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
